// >>> src/stall_detector.v
// stepper stall detector: coil bridge control, integrator and modulus counter
`include "stall_detector_consts.vh"
module stall_detector (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_stop_mode,
  input wire i_wait_mode,
  input wire i_sd_sample,
  output reg o_converter_enable_q,
  output reg o_converter_reset_q,
  output reg [1:0] o_sine_coil_bridge,
  output reg [1:0] o_cosine_coil_bridge,
  output reg o_sense_sine_q,
  output reg o_motor_select,
  output reg o_counter_underflow_flag,
  output reg o_accumulator_overflow_flag
);

  // =========================================================
  // registers
  reg [7:0] ctl_q;
  reg [7:0] step_q;
  reg misc_q;
  reg [15:0] load_q;
  reg [15:0] cnt_q;
  reg [15:0] acc_q;
  reg [15:0] offset_q;
  reg integ_timed_q;
  reg [9:0] sdiv_q;
  reg [9:0] pdiv_q;
  reg [1:0] sclk_sel_q;
  reg [7:0] lo_buf_q;

  // mode is the integrate bit above the drive bit
  wire [1:0] mode = {step_q[`SD_STEP_INTEG], step_q[`SD_STEP_DRIVE]};
  // coils left alone by this block unless enabled
  wire rz_en = ctl_q[`SD_CTL_RZ_EN];
  wire [1:0] step_idx = step_q[`SD_STEP_IDX_HI:`SD_STEP_IDX_LO];
  // =========================================================
  // power-down
  // stop halts block
  // wait with disable
  // low-power inputs are levels, no edge detection needed
  // halting also freezes the prescaler, so counts resume exactly
  wire halted = i_stop_mode | (i_wait_mode & ctl_q[`SD_CTL_WAI]);
  wire conv_on = ctl_q[`SD_CTL_PWRUP] & ~halted;
  wire blanking = (mode == `SD_MODE_BLANK) | (mode == `SD_MODE_BLANK_DRV);
  wire integ = (mode == `SD_MODE_INTEG);

  // =========================================================
  // functions
  // sample divide ratio; bus over 8 times 2^sel
  function [9:0] sample_div;
    input [1:0] sel;
    begin
      sample_div = `SD_SAMPLE_BASE << sel;
    end
  endfunction

  // full-step polarity; step 0 sine+, 1 cos+, 2 sine-, 3 cos
  function [1:0] drive_pol;
    input [1:0] idx;
    input is_sine;
    begin
      case ({is_sine, idx})
        3'b100: drive_pol = `SD_BR_POS;
        3'b110: drive_pol = `SD_BR_NEG;
        3'b001: drive_pol = `SD_BR_POS;
        3'b011: drive_pol = `SD_BR_NEG;
        default: drive_pol = `SD_BR_OFF;
      endcase
    end
  endfunction

  // saturating add; clamp on overflow
  function [16:0] sat_add;
    input [15:0] a;
    input [15:0] b;
    reg [15:0] s;
    begin
      s = a + b;
      if (~a[15] & ~b[15] & s[15])
        sat_add = {1'b1, `SD_ACC_MAX};
      else if (a[15] & b[15] & ~s[15])
        sat_add = {1'b1, `SD_ACC_MIN};
      else
        sat_add = {1'b0, s};
    end
  endfunction

  // =========================================================
  // coil bridges
  // sense coil is the one not energised by the current step
  wire sense_sine = step_idx[0];
  reg [1:0] sine_d;
  reg [1:0] cos_d;
  reg [1:0] masked_d;
  reg [1:0] driven_d;
  always @* begin
    masked_d = `SD_BR_OFF;
    driven_d = `SD_BR_OFF;
    case (mode)
      `SD_MODE_BLANK: begin
        masked_d = `SD_BR_RECIRC;
        driven_d = `SD_BR_OFF;
      end
      `SD_MODE_BLANK_DRV: begin
        masked_d = `SD_BR_RECIRC;
        driven_d = drive_pol(step_idx, ~sense_sine);
      end
      `SD_MODE_CONV: begin
        masked_d = `SD_BR_OFF;
        driven_d = `SD_BR_OFF;
      end
      `SD_MODE_INTEG: begin
        masked_d = `SD_BR_OFF;
        driven_d = drive_pol(step_idx, ~sense_sine);
      end
      default: begin
        masked_d = `SD_BR_OFF;
        driven_d = `SD_BR_OFF;
      end
    endcase
    // stopped recirculation keeps the coils safe
    if (halted) begin
      masked_d = `SD_BR_RECIRC;
      driven_d = `SD_BR_RECIRC;
    end
    // disabled: both bridges released to the motor driver
    if (!rz_en) begin
      sine_d = `SD_BR_OFF;
      cos_d = `SD_BR_OFF;
    end else if (sense_sine) begin
      sine_d = masked_d;
      cos_d = driven_d;
    end else begin
      sine_d = driven_d;
      cos_d = masked_d;
    end
  end

  // =========================================================
  // sample strobe and counter prescale
  // sample rate change takes effect only outside integration
  // sample divider keeps reloading outside integration,
  // so the first sample lands one full period after entry
  wire sample_tick = (sdiv_q == `SD_DIV_ONE);
  wire [9:0] pre_div = misc_q ? `SD_PRE_LONG : `SD_PRE_SHORT;
  wire cnt_tick = (pdiv_q == `SD_DIV_ONE) & ~halted;
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sdiv_q <= `SD_SAMPLE_BASE;
      pdiv_q <= `SD_PRE_SHORT;
      sclk_sel_q <= 2'h0;
    end else begin
      if (!integ)
        sclk_sel_q <= ctl_q[`SD_CTL_SCLK_HI:`SD_CTL_SCLK_LO];
      if (!integ || sample_tick)
        sdiv_q <= sample_div(sclk_sel_q);
      else
        sdiv_q <= sdiv_q - `SD_DIV_ONE;
      if (!halted) begin
        if (cnt_tick | (pdiv_q == `SD_DIV_ONE))
          pdiv_q <= pre_div;
        else
          pdiv_q <= pdiv_q - `SD_DIV_ONE;
      end
    end
  end

  // =========================================================
  // accumulator with offset compensation
  wire acc_step = integ & sample_tick & conv_on;
  wire [15:0] delta = i_sd_sample ? `SD_ONE16 : (`SD_ZERO16 - `SD_ONE16);
  wire [16:0] acc_sum = sat_add(acc_q, delta);
  wire ovf_set = acc_step & acc_sum[16];
  wire under_set = cnt_tick & (cnt_q == `SD_ONE16);
  wire flag_wr = i_wr & (i_addr == `SD_ADDR_FLAG);
  wire cnt_wr_lo = i_wr & (i_addr == `SD_ADDR_CNT_LO);
  wire [15:0] cnt_wval = {lo_buf_q, i_wdata};
  // offset sums share the saturating adder; top bit is the clamp marker
  wire [16:0] off_sum = sat_add(offset_q, delta);
  wire [16:0] comp_sum = sat_add(acc_q, `SD_ZERO16 - offset_q);
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_q <= `SD_ZERO16;
      offset_q <= `SD_ZERO16;
      integ_timed_q <= 1'b0;
    end else begin
      if (blanking) begin
        acc_q <= `SD_ZERO16;
        integ_timed_q <= 1'b0;
      end else if (acc_step && integ) begin
        acc_q <= acc_sum[15:0];
      end else if (!integ) begin
        // divider reloads outside integration, so conversion mode samples the offset at most once, just after leaving integration
        if (acc_step)
          acc_q <= acc_sum[15:0];
      end
      if (mode == `SD_MODE_CONV && sample_tick && conv_on)
        offset_q <= off_sum[15:0];
      if (integ && cnt_q != `SD_ZERO16)
        integ_timed_q <= 1'b1;
      if (integ && integ_timed_q && under_set)
        acc_q <= comp_sum[15:0];
    end
  end

  // =========================================================
  // modulus down counter
  // high byte is buffered so a byte-wise load never counts from a half value
  // limitation: no reload on underflow, software rearms each interval
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= `SD_ZERO16;
      load_q <= `SD_ZERO16;
      lo_buf_q <= 8'h00;
    end else begin
      if (i_wr && i_addr == `SD_ADDR_CNT_HI)
        lo_buf_q <= i_wdata;
      if (i_wr && i_addr == `SD_ADDR_LOAD_HI)
        load_q[15:8] <= i_wdata;
      if (i_wr && i_addr == `SD_ADDR_LOAD_LO)
        load_q[7:0] <= i_wdata;
      if (cnt_wr_lo)
        cnt_q <= cnt_wval;
      else if (cnt_tick && cnt_q != `SD_ZERO16)
        cnt_q <= cnt_q - `SD_ONE16;
    end
  end

  // =========================================================
  // register writes and flags
  // flags are sticky; a clear racing a new event loses, so no event is missed
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctl_q <= `SD_CTL_RST;
      step_q <= `SD_STEP_RST;
      misc_q <= 1'b0;
      o_accumulator_overflow_flag <= 1'b0;
      o_counter_underflow_flag <= 1'b0;
    end else begin
      if (i_wr && i_addr == `SD_ADDR_CTL)
        ctl_q <= i_wdata;
      if (i_wr && i_addr == `SD_ADDR_STEP)
        step_q <= i_wdata;
      if (i_wr && i_addr == `SD_ADDR_MISC)
        misc_q <= i_wdata[`SD_MISC_PRE];
      if (ovf_set)
        o_accumulator_overflow_flag <= 1'b1;
      else if (flag_wr && i_wdata[`SD_FLG_OVF])
        o_accumulator_overflow_flag <= 1'b0;
      if (under_set)
        o_counter_underflow_flag <= 1'b1;
      else if (flag_wr && i_wdata[`SD_FLG_UNDER])
        o_counter_underflow_flag <= 1'b0;
    end
  end

  // =========================================================
  // outputs and read data
  // every output registered: one cycle of latency traded for clean pins
  // read data returns to zero outside the answer cycle
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
      o_converter_enable_q <= 1'b0;
      o_converter_reset_q <= 1'b1;
      o_sine_coil_bridge <= `SD_BR_OFF;
      o_cosine_coil_bridge <= `SD_BR_OFF;
      o_sense_sine_q <= 1'b0;
      o_motor_select <= 1'b0;
    end else begin
      o_converter_enable_q <= conv_on;
      o_converter_reset_q <= blanking | ~conv_on;
      o_sine_coil_bridge <= sine_d;
      o_cosine_coil_bridge <= cos_d;
      o_sense_sine_q <= sense_sine;
      o_motor_select <= step_q[`SD_STEP_MSEL];
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `SD_ADDR_CTL: o_rdata <= ctl_q;
          `SD_ADDR_STEP: o_rdata <= step_q;
          `SD_ADDR_FLAG: o_rdata <= {o_counter_underflow_flag, 6'h00, o_accumulator_overflow_flag};
          `SD_ADDR_LOAD_HI: o_rdata <= load_q[15:8];
          `SD_ADDR_LOAD_LO: o_rdata <= load_q[7:0];
          `SD_ADDR_CNT_HI: o_rdata <= cnt_q[15:8];
          `SD_ADDR_CNT_LO: o_rdata <= cnt_q[7:0];
          `SD_ADDR_ACC_HI: o_rdata <= acc_q[15:8];
          `SD_ADDR_ACC_LO: o_rdata <= acc_q[7:0];
          `SD_ADDR_MISC: o_rdata <= {7'h00, misc_q};
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // stall_detector

// >>> src/stall_detector_consts.vh
// constants for the stepper stall detector
`ifndef STALL_DETECTOR_CONSTS_VH
`define STALL_DETECTOR_CONSTS_VH
// register offsets (plain register port, byte wide data)
`define SD_ADDR_CTL 4'h0
`define SD_ADDR_STEP 4'h1
`define SD_ADDR_FLAG 4'h2
`define SD_ADDR_LOAD_HI 4'h3
`define SD_ADDR_LOAD_LO 4'h4
`define SD_ADDR_CNT_HI 4'h5
`define SD_ADDR_CNT_LO 4'h6
`define SD_ADDR_ACC_HI 4'h7
`define SD_ADDR_ACC_LO 4'h8
`define SD_ADDR_MISC 4'h9
// control register fields
`define SD_CTL_RZ_EN 7
`define SD_CTL_PWRUP 6
`define SD_CTL_WAI 5
`define SD_CTL_SCLK_HI 1
`define SD_CTL_SCLK_LO 0
// step register fields
`define SD_STEP_INTEG 7
`define SD_STEP_DRIVE 6
`define SD_STEP_RECIRC 5
`define SD_STEP_MSEL 4
`define SD_STEP_IDX_HI 1
`define SD_STEP_IDX_LO 0
// flag register fields
`define SD_FLG_UNDER 7
`define SD_FLG_OVF 0
// misc register fields
`define SD_MISC_PRE 0
// reset values
`define SD_CTL_RST 8'h40
`define SD_STEP_RST 8'h00
`define SD_ZERO16 16'h0000
`define SD_ONE16 16'h0001
`define SD_ACC_MAX 16'h7fff
`define SD_ACC_MIN 16'h8000
// sample divider base 8, counter prescale 64 or 512
`define SD_SAMPLE_BASE 10'd8
`define SD_PRE_SHORT 10'd64
`define SD_PRE_LONG 10'd512
`define SD_DIV_ONE 10'd1
// modes
`define SD_MODE_BLANK 2'b00
`define SD_MODE_BLANK_DRV 2'b01
`define SD_MODE_CONV 2'b10
`define SD_MODE_INTEG 2'b11
// bridge codes: 00 off, 01 positive, 10 negative, 11 recirculate
`define SD_BR_OFF 2'b00
`define SD_BR_POS 2'b01
`define SD_BR_NEG 2'b10
`define SD_BR_RECIRC 2'b11
`endif

// >>> dv/stall_detector_props.sv
// assertion checker on the stall detector ports
module stall_detector_props (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_stop_mode,
  input wire i_wait_mode,
  input wire o_converter_enable_q,
  input wire o_converter_reset_q,
  input wire [1:0] o_sine_coil_bridge,
  input wire [1:0] o_cosine_coil_bridge,
  input wire o_sense_sine_q,
  input wire o_counter_underflow_flag,
  input wire o_accumulator_overflow_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // ==========
  // shadow of the control and step writes
  logic [7:0] ctl_q, stp_q, pctl_q, pstp_q;
  logic halt_q;
  wire wt = i_wait_mode & ctl_q[5];
  wire halt = i_stop_mode | wt;
  wire pd = halt | ~ctl_q[6];
  wire [1:0] sb = o_sense_sine_q ? o_sine_coil_bridge : o_cosine_coil_bridge;
  wire [1:0] ob = o_sense_sine_q ? o_cosine_coil_bridge : o_sine_coil_bridge;
  // low index bit must be steady, sense select and bridges may land apart
  wire rz = pctl_q[7] & ~halt_q & (pstp_q[0] == stp_q[0]);
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctl_q <= 8'h40;
      stp_q <= 8'h00;
      pctl_q <= 8'h40;
      pstp_q <= 8'h00;
      halt_q <= 1'b0;
    end else begin
      if (i_wr && i_addr == 4'h0) ctl_q <= i_wdata;
      if (i_wr && i_addr == 4'h1) stp_q <= i_wdata;
      pctl_q <= ctl_q;
      pstp_q <= stp_q;
      halt_q <= halt;
    end
  end
  // ==========
  // properties
  stop_pd_a: assert property ($past(i_stop_mode) |-> !o_converter_enable_q) else $error("on in stop");
  wait_pd_a: assert property ($past(wt) |-> !o_converter_enable_q) else $error("on in wait");
  pwr_off_a: assert property (!$past(ctl_q[6]) |-> !o_converter_enable_q) else $error("on unpowered");
  pwr_on_a: assert property (!$past(i_sys_rst) && !$past(pd) |-> o_converter_enable_q) else $error("off when due");
  blank_rst_a: assert property (!$past(stp_q[7]) |-> o_converter_reset_q) else $error("no reset");
  sense_br_a: assert property (rz |-> sb == (pstp_q[7] ? 2'b00 : 2'b11)) else $error("sense coil");
  other_br_a: assert property (rz |-> (pstp_q[6] ? ^ob : ob == 2'b00)) else $error("other coil");
  sense_sel_a: assert property ($stable(stp_q[0]) |-> o_sense_sine_q == stp_q[0]) else $error("sense sel");
  ovf_hold_a: assert property (o_accumulator_overflow_flag && !(i_wr && i_addr == 4'h2 && i_wdata[0])
    |=> o_accumulator_overflow_flag) else $error("ovf lost");
  uf_hold_a: assert property (o_counter_underflow_flag && !(i_wr && i_addr == 4'h2 && i_wdata[7])
    |=> o_counter_underflow_flag) else $error("uf lost");
endmodule // stall_detector_props
bind stall_detector stall_detector_props props_i (.*);

// >>> dv/coil_model.sv
// back-emf model of the sensed stepper coil
module coil_model (
  input wire i_clk_sys,
  input wire i_moving,
  input wire i_up,
  input wire [1:0] i_sense_br,
  output logic o_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog_q = 1'b0;
  always @(posedge i_clk_sys) tog_q <= ~tog_q;
  // emf only reaches the converter from an open bridge, else churn
  assign o_bit = (i_moving && i_sense_br == 2'b00) ? i_up : tog_q;
endmodule // coil_model

// >>> dv/tb_stall_detector.sv
// self-checking bench for the stall detector
`include "stall_detector_consts.vh"
module tb_stall_detector;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, stp = 1'b0, wt = 1'b0, mv = 1'b0, up = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, h, l;
  wire [7:0] rdata;
  wire en, crst, ssn, ms, uf, of, smp;
  wire [1:0] sbr, cbr;
  wire [1:0] sb = ssn ? sbr : cbr;
  wire [1:0] ob = ssn ? cbr : sbr;
  int n_errors = 0, checks = 0;
  always #5 clk = ~clk;
  stall_detector uut (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_stop_mode(stp), .i_wait_mode(wt), .i_sd_sample(smp), .o_converter_enable_q(en),
    .o_converter_reset_q(crst), .o_sine_coil_bridge(sbr), .o_cosine_coil_bridge(cbr), .o_sense_sine_q(ssn),
    .o_motor_select(ms), .o_counter_underflow_flag(uf), .o_accumulator_overflow_flag(of));
  coil_model pm (.i_clk_sys(clk), .i_moving(mv), .i_up(up), .i_sense_br(sb), .o_bit(smp));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    rreg(a, h);
    chk(nm, {8'h00, e}, {8'h00, h});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // sample phase is unknown, so allow two counts either way
  task automatic integ(input logic [7:0] c, input logic u, input int n, input logic [15:0] e);
    wreg(`SD_ADDR_STEP, 8'h01);
    wreg(`SD_ADDR_CTL, c);
    up <= u;
    mv <= 1'b1;
    wreg(`SD_ADDR_STEP, 8'hc1);
    idle(n);
    rreg(`SD_ADDR_ACC_HI, h);
    rreg(`SD_ADDR_ACC_LO, l);
    chk("acc", 16'h1, {15'h0, ({h, l} - e + 16'h2) <= 16'h4});
    chk("ovf_none", 16'h0, {15'h0, of});
  endtask
  task automatic see_uf(input int n);
    for (int k = 0; k < n && uf !== 1'b1; k++) @(posedge clk);
    chk("uf", 16'h1, {15'h0, uf});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100us;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("ctl", `SD_ADDR_CTL, 8'h40);
    rchk("unmapped", 4'hf, 8'h00);
    rchk("acc0", `SD_ADDR_ACC_LO, 8'h00);
    chk("coils_off", 16'h0, {12'h0, sbr, cbr});
    $display("reset test done");
    wreg(`SD_ADDR_CTL, 8'hc0);
    for (int i = 0; i < 16; i++) begin
      wreg(`SD_ADDR_STEP, {i[3:2], 4'h0, i[1:0]});
      idle(2);
      chk("sense", {15'h0, i[0]}, {15'h0, ssn});
      chk("sense_br", i[3] ? 16'h0 : 16'h3, {14'h0, sb});
      chk("other_br", 16'h1, {15'h0, i[2] ? ^ob : ob == 2'b00});
    end
    $display("mode test done");
    integ(8'hc0, 1'b1, 160, 16'h0014);
    integ(8'hc0, 1'b0, 160, 16'hffec);
    integ(8'hc1, 1'b1, 160, 16'h000a);
    integ(8'hc3, 1'b0, 640, 16'hfff6);
    $display("integrate test done");
    wreg(`SD_ADDR_STEP, 8'h01);
    wreg(`SD_ADDR_CTL, 8'hc0);
    wreg(`SD_ADDR_MISC, 8'h00);
    wreg(`SD_ADDR_CNT_HI, 8'h00);
    wreg(`SD_ADDR_CNT_LO, 8'h03);
    idle(100);
    chk("uf_early", 16'h0, {15'h0, uf});
    see_uf(200);
    wreg(`SD_ADDR_FLAG, 8'h01);
    rchk("uf_kept", `SD_ADDR_FLAG, 8'h80);
    wreg(`SD_ADDR_FLAG, 8'h80);
    rchk("uf_clr", `SD_ADDR_FLAG, 8'h00);
    wreg(`SD_ADDR_CNT_LO, 8'h00);
    idle(200);
    chk("uf_zero", 16'h0, {15'h0, uf});
    wreg(`SD_ADDR_CNT_LO, 8'h02);
    stp <= 1'b1;
    idle(300);
    chk("stop", 16'h000f, {10'h0, uf, en, sbr, cbr});
    stp <= 1'b0;
    see_uf(200);
    chk("en_back", 16'h1, {15'h0, en});
    $display("counter test done");
    wt <= 1'b1;
    idle(2);
    chk("wait_run", 16'h1, {15'h0, en});
    wreg(`SD_ADDR_CTL, 8'he0);
    idle(2);
    chk("wait_off", 16'h0, {15'h0, en});
    wt <= 1'b0;
    idle(2);
    chk("wait_exit", 16'h1, {15'h0, en});
    wreg(`SD_ADDR_CTL, 8'h80);
    idle(2);
    chk("pwr_off", 16'h0, {15'h0, en});
    wreg(`SD_ADDR_STEP, 8'h10);
    idle(2);
    chk("msel", 16'h1, {15'h0, ms});
    $display("power test done");
    tally_and_finish();
  end
endmodule // tb_stall_detector
